// file: hw/meb_pkg.sv
// Constants and types shared by the external bus and pin block
package meb_pkg;

  // Core clock stands in for the oscillator: one slot per clock period
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int unsigned CLOCK_PERIOD_NS = 25;

  // Machine cycle of fifteen slots, numbered 0 to 14
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_LAST = 4'he;

  // Strobe windows inside the machine cycle, [on, off) in slots
  localparam logic [3:0] ALE_ON = 4'h1;
  localparam logic [3:0] ALE_OFF = 4'h4;
  localparam logic [3:0] ADDR_END = 4'h5;
  localparam logic [3:0] CODE_ON = 4'h6;
  localparam logic [3:0] CODE_OFF = 4'hc;
  localparam logic [3:0] DATA_ON = 4'h6;
  localparam logic [3:0] DATA_OFF = 4'he;
  localparam logic [3:0] PROG_ON = 4'h6;
  localparam logic [3:0] PROG_OFF = 4'he;

  // Values after reset, and the drive mask for the port two low nibble
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [7:0] BUS_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [3:0] NIB_DRIVE = 4'hf;

  // Size of the program space that the counter can reach
  localparam int unsigned CODE_SPACE = 4096;

  // Width of the pin synchroniser bank
  localparam int unsigned SYNC_W = 29;

  // Kind of machine cycle asked for by the core
  typedef enum logic [2:0] {
    MEB_K_FETCH = 3'h0,
    MEB_K_DREAD = 3'h1,
    MEB_K_DWRITE = 3'h2,
    MEB_K_XREAD = 3'h3,
    MEB_K_XWRITE = 3'h4,
    MEB_K_P1WR = 3'h5,
    MEB_K_P2WR = 3'h6,
    MEB_K_IDLE = 3'h7
  } meb_kind_e;

  // Sequencer states
  typedef enum logic [1:0] {
    MEB_RUN = 2'b01,
    MEB_HALT = 2'b10
  } meb_state_e;

endpackage

// file: hw/meb_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module meb_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] reset_val,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (srst) begin
        meta_reg[i] <= reset_val[i]; // Idle level in both stages, no false edge at release
        sync_reg[i] <= reset_val[i];
      end else begin
        meta_reg[i] <= async_in[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

// file: hw/meb_bus_unit.sv
// External bus sequencer, strobes, ports and test pins of the microcomputer
// Function
// (RULE1) Test zero level steers its branch
// (RULE2) Clock-out enable drives internal clock on test zero
// (RULE3) Single-step low halts after each instruction, ALE high
// (RULE4) Interrupt pin feeds branch and interrupt request
// (RULE5) External-fetch select high forces external program fetches
// (RULE6) Read strobe pulses for data and bus input
// (RULE7) Write strobe pulses for data and bus output
// (RULE8) Code fetch strobe reads external instruction bytes
// (RULE9) One ALE pulse in every machine cycle
// (RULE10) Bidirectional data bus, output data latched
// (RULE11) Fetch: low counter byte with ALE, code strobe
// (RULE12) Data access: address with ALE, data on strobe
// (RULE13) Software writes ones before using port inputs
// (RULE14) Ports usable as inputs straight after reset
// (RULE15) Port two low nibble carries high counter bits
// (RULE16) Port two low nibble is expander bus
// (RULE17) Expander strobe qualifies expander transfers
// (RULE18) Test one steers branch and feeds counter
// (RULE19) Machine cycle is fifteen oscillator periods
`timescale 1ns/1ps
`default_nettype none
module meb_bus_unit
  import meb_pkg::*;
#(
  parameter int unsigned INT_CODE_SIZE = 4096
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic cyc_req,
  input wire meb_kind_e cyc_kind,
  input wire logic [11:0] cyc_addr,
  input wire logic [7:0] cyc_wdata,
  input wire logic cyc_last,
  output logic cyc_taken,
  output logic cyc_done,
  output logic [7:0] cyc_rdata,
  input wire logic clock_out_enable,
  input wire logic counter_run,
  input wire logic irq_ack,
  output logic test0_level,
  output logic test1_level,
  output logic irq_level_n,
  output logic irq_pending,
  output logic t1_event,
  output logic step_halted,
  output logic [7:0] port1_level,
  output logic [7:0] port2_level,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe,
  output logic ale,
  output logic code_fetch_strobe_n,
  output logic rd_n,
  output logic wr_n,
  output logic expander_strobe_n,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  input wire logic [7:0] p2_in,
  output logic [7:0] p2_out,
  output logic [7:0] p2_oe,
  input wire logic test_input_zero_in,
  output logic test_input_zero_out,
  output logic test_input_zero_oe,
  input wire logic test_input_one,
  input wire logic irq_n,
  input wire logic single_step_n,
  input wire logic external_fetch_select
);

  if (INT_CODE_SIZE > CODE_SPACE) begin : g_bad_size
    $error("INT_CODE_SIZE exceeds the program space");
  end

  // True when slot lies inside the window [on, off)
  function automatic logic in_win(input logic [3:0] s, input logic [3:0] on,
                                  input logic [3:0] off);
    in_win = (s >= on) && (s < off);
  endfunction

  // Pin synchronisers; idle levels after reset are high for active-low pins
  logic [SYNC_W-1:0] s_vec;
  logic t0_s, t1_s, irq_s, ss_s, ea_s;
  logic [7:0] bus_s, p1_s, p2_s;
  meb_sync #(.W(SYNC_W)) u_sync (
    .clock(clock),
    .srst(srst),
    .async_in({p2_in, p1_in, bus_in, external_fetch_select, single_step_n, irq_n,
               test_input_one, test_input_zero_in}),
    .reset_val({PORT_RESET, PORT_RESET, BUS_RESET, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0}),
    .sync_out(s_vec)
  );
  assign {p2_s, p1_s, bus_s, ea_s, ss_s, irq_s, t1_s, t0_s} = s_vec;

  // Sequencer state
  meb_state_e state_reg, state_next;
  logic [3:0] slot_reg, slot_next;
  meb_kind_e kind_reg, kind_next;
  logic [11:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic last_reg, last_next;
  logic ext_reg, ext_next;
  logic taken_reg, taken_next;
  logic take;

  // Cycle sequencer: slots run except in single-step halt; request taken at each cycle boundary that does not halt, and on resume
  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    kind_next = kind_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    last_next = last_reg;
    ext_next = ext_reg;
    take = 1'b0;
    case (state_reg)
      MEB_RUN: begin
        if (slot_reg == SLOT_LAST) begin // RULE19
          slot_next = SLOT_FIRST;
          if (last_reg && kind_reg != MEB_K_IDLE && !ss_s) begin
            state_next = MEB_HALT; // RULE3
            kind_next = MEB_K_IDLE;
          end else begin
            take = 1'b1;
          end
        end else begin
          slot_next = slot_reg + 4'h1;
        end
      end
      MEB_HALT: begin
        slot_next = SLOT_FIRST;
        if (ss_s) begin
          state_next = MEB_RUN; // RULE3
          take = 1'b1;
        end
      end
      default: begin
        state_next = MEB_RUN;
        slot_next = SLOT_FIRST;
      end
    endcase
    if (take) begin
      kind_next = cyc_req ? cyc_kind : MEB_K_IDLE;
      addr_next = cyc_addr;
      wdata_next = cyc_wdata;
      last_next = cyc_last;
      // Fetch goes outside when forced or above the internal store
      ext_next = cyc_req && cyc_kind == MEB_K_FETCH &&
                 (ea_s || int'(cyc_addr) >= int'(INT_CODE_SIZE)); // RULE5
    end
    taken_next = take && cyc_req;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= MEB_RUN;
      slot_reg <= SLOT_FIRST;
      kind_reg <= MEB_K_IDLE;
      addr_reg <= ADDR_RESET;
      wdata_reg <= BUS_RESET;
      last_reg <= 1'b0;
      ext_reg <= 1'b0;
      taken_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      kind_reg <= kind_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      last_reg <= last_next;
      ext_reg <= ext_next;
      taken_reg <= taken_next;
    end
  end

  // Pin outputs, all registered one slot behind the sequencer
  logic ale_reg, ale_next, code_n_reg, code_n_next, rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next, prog_n_reg, prog_n_next, bus_oe_reg, bus_oe_next;
  logic [7:0] bus_out_reg, bus_out_next, p1_lat_reg, p1_lat_next, p2_lat_reg, p2_lat_next;
  logic [7:0] p2_out_reg, p2_out_next, p2_oe_reg, p2_oe_next, rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic is_xfer, is_addr_cyc;

  // Strobe and bus decode for the current slot
  always_comb begin
    is_xfer = (kind_reg == MEB_K_XREAD) || (kind_reg == MEB_K_XWRITE);
    is_addr_cyc = ext_reg || kind_reg == MEB_K_DREAD || kind_reg == MEB_K_DWRITE;
    ale_next = (state_reg == MEB_HALT) || in_win(slot_reg, ALE_ON, ALE_OFF); // RULE9 RULE3
    code_n_next = !(ext_reg && in_win(slot_reg, CODE_ON, CODE_OFF)); // RULE8
    rd_n_next = !(kind_reg == MEB_K_DREAD && in_win(slot_reg, DATA_ON, DATA_OFF)); // RULE6
    wr_n_next = !(kind_reg == MEB_K_DWRITE && in_win(slot_reg, DATA_ON, DATA_OFF)); // RULE7
    prog_n_next = !(is_xfer && in_win(slot_reg, PROG_ON, PROG_OFF)); // RULE17
    bus_out_next = bus_out_reg;
    bus_oe_next = 1'b0;
    if (state_reg == MEB_RUN && slot_reg < ADDR_END && is_addr_cyc) begin
      bus_out_next = addr_reg[7:0]; // RULE11 RULE12
      bus_oe_next = 1'b1;
    end else if (state_reg == MEB_RUN && kind_reg == MEB_K_DWRITE) begin
      bus_out_next = wdata_reg; // RULE10
      bus_oe_next = 1'b1;
    end
    // Port latches; reset to all ones so pins read as inputs at once
    p1_lat_next = p1_lat_reg;
    p2_lat_next = p2_lat_reg;
    if (slot_reg == SLOT_LAST && kind_reg == MEB_K_P1WR) begin
      p1_lat_next = wdata_reg;
    end
    if (slot_reg == SLOT_LAST && kind_reg == MEB_K_P2WR) begin
      p2_lat_next = wdata_reg;
    end
    // Quasi-bidirectional: only a zero is driven hard, except the low nibble while it carries address or expander data
    p2_out_next = p2_lat_reg;
    p2_oe_next = ~p2_lat_reg; // RULE14
    if (ext_reg && slot_reg < ADDR_END) begin
      p2_out_next[3:0] = addr_reg[11:8]; // RULE15
      p2_oe_next[3:0] = NIB_DRIVE;
    end else if (is_xfer && slot_reg < PROG_ON) begin
      p2_out_next[3:0] = addr_reg[3:0]; // RULE16
      p2_oe_next[3:0] = NIB_DRIVE;
    end else if (kind_reg == MEB_K_XWRITE && slot_reg < PROG_OFF) begin
      p2_out_next[3:0] = wdata_reg[3:0]; // RULE16
      p2_oe_next[3:0] = NIB_DRIVE;
    end else if (kind_reg == MEB_K_XREAD && slot_reg < PROG_OFF) begin
      p2_oe_next[3:0] = 4'h0; // Released so the expander can answer
    end
    // Capture read data in the last slot of each strobe
    rdata_next = rdata_reg;
    if (ext_reg && slot_reg == CODE_OFF - 4'h1) begin
      rdata_next = bus_s; // RULE11
    end else if (kind_reg == MEB_K_DREAD && slot_reg == DATA_OFF - 4'h1) begin
      rdata_next = bus_s; // RULE12
    end else if (kind_reg == MEB_K_XREAD && slot_reg == PROG_OFF - 4'h1) begin
      rdata_next = {4'h0, p2_s[3:0]};
    end
    done_next = state_reg == MEB_RUN && slot_reg == SLOT_LAST && kind_reg != MEB_K_IDLE;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ale_reg <= 1'b0;
      code_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      prog_n_reg <= 1'b1;
      bus_out_reg <= BUS_RESET;
      bus_oe_reg <= 1'b0;
      p1_lat_reg <= PORT_RESET;
      p2_lat_reg <= PORT_RESET;
      p2_out_reg <= PORT_RESET;
      p2_oe_reg <= 8'h00;
      rdata_reg <= BUS_RESET;
      done_reg <= 1'b0;
    end else begin
      ale_reg <= ale_next;
      code_n_reg <= code_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      prog_n_reg <= prog_n_next;
      bus_out_reg <= bus_out_next;
      bus_oe_reg <= bus_oe_next;
      p1_lat_reg <= p1_lat_next;
      p2_lat_reg <= p2_lat_next;
      p2_out_reg <= p2_out_next;
      p2_oe_reg <= p2_oe_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
    end
  end

  // Test pins, interrupt and counter input
  logic t0_oe_reg, t0_oe_next, t0_clk_reg, t0_clk_next, t1_old_reg, t1_ev_reg, t1_ev_next;
  logic irq_pend_reg, irq_pend_next;

  // Interrupt set wins over a same-cycle acknowledge
  always_comb begin
    t0_oe_next = clock_out_enable; // RULE2
    t0_clk_next = !t0_clk_reg;
    t1_ev_next = counter_run && t1_old_reg && !t1_s; // RULE18
    irq_pend_next = !irq_s || (irq_pend_reg && !irq_ack); // RULE4
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      t0_oe_reg <= 1'b0;
      t0_clk_reg <= 1'b0;
      t1_old_reg <= 1'b0;
      t1_ev_reg <= 1'b0;
      irq_pend_reg <= 1'b0;
    end else begin
      t0_oe_reg <= t0_oe_next;
      t0_clk_reg <= t0_clk_next;
      t1_old_reg <= t1_s;
      t1_ev_reg <= t1_ev_next;
      irq_pend_reg <= irq_pend_next;
    end
  end

  // Output wiring, every port from a flip-flop; step_halted decodes state_reg, p1_oe inverts p1_lat_reg
  assign cyc_taken = taken_reg;
  assign cyc_done = done_reg;
  assign cyc_rdata = rdata_reg;
  assign test0_level = t0_s; // RULE1
  assign test1_level = t1_s; // RULE18
  assign irq_level_n = irq_s; // RULE4
  assign irq_pending = irq_pend_reg;
  assign t1_event = t1_ev_reg;
  assign step_halted = state_reg == MEB_HALT;
  assign port1_level = p1_s;
  assign port2_level = p2_s;
  assign bus_out = bus_out_reg;
  assign bus_oe = bus_oe_reg;
  assign ale = ale_reg;
  assign code_fetch_strobe_n = code_n_reg;
  assign rd_n = rd_n_reg;
  assign wr_n = wr_n_reg;
  assign expander_strobe_n = prog_n_reg;
  assign p1_out = p1_lat_reg;
  assign p1_oe = ~p1_lat_reg; // RULE14
  assign p2_out = p2_out_reg;
  assign p2_oe = p2_oe_reg;
  assign test_input_zero_out = t0_clk_reg;
  assign test_input_zero_oe = t0_oe_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_ale_once: assert property (!step_halted && slot_reg == SLOT_LAST |-> // RULE9
    ##[2:3] ($rose(ale) || step_halted))
    else $error("ALE did not follow the machine cycle boundary");
  a_slot_range: assert property (slot_reg <= SLOT_LAST) // RULE19
    else $error("slot counter left the machine cycle");
  a_code_width: assert property ($fell(code_fetch_strobe_n) |-> // RULE8
    !code_fetch_strobe_n[*6] ##1 code_fetch_strobe_n)
    else $error("code fetch strobe width wrong");
  a_rd_width: assert property ($fell(rd_n) |-> !rd_n[*8] ##1 rd_n) // RULE6
    else $error("read strobe width wrong");
  a_rd_release: assert property (!rd_n || !code_fetch_strobe_n |-> !bus_oe) // RULE10
    else $error("bus driven during a read strobe");
  a_wr_data: assert property (!wr_n |-> bus_oe && bus_out == wdata_reg) // RULE7
    else $error("write data not on the bus during write strobe");
  a_pc_high: assert property ($rose(ale) && ext_reg |-> p2_oe[3:0] == NIB_DRIVE && // RULE15
    p2_out[3:0] == addr_reg[11:8])
    else $error("high counter bits missing on port two");
  a_prog_kind: assert property ($fell(expander_strobe_n) |-> is_xfer) // RULE17
    else $error("expander strobe outside expander cycle");
  a_port_reset: assert property ($past(srst) |-> p1_oe == 8'h00 && p2_oe == 8'h00) // RULE14
    else $error("ports drive low after reset");
  a_t0_clock: assert property (clock_out_enable |=> test_input_zero_oe && // RULE2
    test_input_zero_out != $past(test_input_zero_out))
    else $error("test zero not driven after clock-out enable");
  a_halt_ale: assert property (step_halted |=> ale || !step_halted) // RULE3
    else $error("ALE low while halted");
  a_irq_pend: assert property (!irq_s |=> irq_pending) // RULE4
    else $error("interrupt level not latched");

  c_ext_fetch: cover property ($fell(code_fetch_strobe_n));
  c_write: cover property ($fell(wr_n) ##[1:20] $fell(ale));
  c_halt: cover property ($rose(step_halted));
  c_expander: cover property ($fell(expander_strobe_n));

endmodule
`default_nettype wire

// file: sim/meb_mem_model.sv
// Behavioural external memory and expander facing the bus unit
`timescale 1ns/1ps
`default_nettype none
module meb_mem_model (
  input wire logic clock,
  input wire logic ale,
  input wire logic code_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic xs_n,
  input wire logic [7:0] bus,
  input wire logic [3:0] nib,
  output logic [7:0] bus_drv,
  output logic [3:0] nib_drv,
  output logic nib_en
);
  logic [7:0] mem [256];
  logic [7:0] adr;
  logic [3:0] hi;
  logic [3:0] cmd;
  logic [3:0] xr [4];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
    for (int i = 0; i < 4; i++) xr[i] = 4'h0;
    bus_drv = 8'h00;
    nib_en = 1'b0;
    nib_drv = 4'h0;
  end
  // Latch addresses, answer strobes; a released bus shows the inverse of its last value
  always @(posedge clock) begin
    if (ale) begin
      adr <= bus;
      hi <= nib;
    end
    if (xs_n) cmd <= nib;
    if (!wr_n) mem[adr] <= bus;
    if (!xs_n && cmd[3:2] == 2'b01) xr[cmd[1:0]] <= nib;
    if (!code_n) bus_drv <= adr ^ {hi, hi};
    else if (!rd_n) bus_drv <= mem[adr];
    else bus_drv <= ~bus_drv;
    nib_en <= !xs_n && cmd[3:2] == 2'b00;
    nib_drv <= xr[cmd[1:0]];
  end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the external bus and pin block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import meb_pkg::*;
  logic clock, srst, cyc_req, cyc_last, coe, counter_run, irq_ack, cyc_taken, cyc_done;
  meb_kind_e cyc_kind;
  logic [11:0] cyc_addr;
  logic [7:0] cyc_wdata, cyc_rdata, port1_level, port2_level, bus_in, bus_out, bus_drv;
  logic [7:0] p1_out, p1_oe, p2_out, p2_oe, p1_ext, p2_ext, p1_pin, p2_pin, d;
  logic test0_level, test1_level, irq_level_n, irq_pending, t1_event, step_halted;
  logic bus_oe, ale, code_n, rd_n, wr_n, xs_n, t0_out, t0_oe, t0_ext, t0_pin;
  logic t1_pin, irq_n, ss_n, efs, nib_en, prev_ale;
  logic [3:0] nib_drv, s_now, s_prev;
  logic [11:0] a;
  int fails, tests_run, n, fall_cnt[4];
  logic [7:0] model [256];
  logic [3:0] xm [4];
  assign bus_in = bus_oe ? bus_out : bus_drv;
  assign p1_pin = (p1_oe & p1_out) | (~p1_oe & p1_ext);
  assign p2_pin = (p2_oe & p2_out) | (~p2_oe & {p2_ext[7:4], nib_en ? nib_drv : p2_ext[3:0]});
  assign t0_pin = t0_oe ? t0_out : t0_ext;
  assign s_now = {code_n, rd_n, wr_n, xs_n};
  meb_bus_unit u_meb_bus_unit (.clock(clock), .srst(srst), .cyc_req(cyc_req),
    .cyc_kind(cyc_kind), .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .cyc_last(cyc_last),
    .cyc_taken(cyc_taken), .cyc_done(cyc_done), .cyc_rdata(cyc_rdata),
    .clock_out_enable(coe), .counter_run(counter_run), .irq_ack(irq_ack),
    .test0_level(test0_level), .test1_level(test1_level), .irq_level_n(irq_level_n),
    .irq_pending(irq_pending), .t1_event(t1_event), .step_halted(step_halted),
    .port1_level(port1_level), .port2_level(port2_level), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .ale(ale), .code_fetch_strobe_n(code_n),
    .rd_n(rd_n), .wr_n(wr_n), .expander_strobe_n(xs_n), .p1_in(p1_pin), .p1_out(p1_out),
    .p1_oe(p1_oe), .p2_in(p2_pin), .p2_out(p2_out), .p2_oe(p2_oe),
    .test_input_zero_in(t0_pin), .test_input_zero_out(t0_out), .test_input_zero_oe(t0_oe),
    .test_input_one(t1_pin), .irq_n(irq_n), .single_step_n(ss_n),
    .external_fetch_select(efs));
  meb_mem_model u_meb_mem_model (.clock(clock), .ale(ale), .code_n(code_n), .rd_n(rd_n),
    .wr_n(wr_n), .xs_n(xs_n), .bus(bus_in), .nib(p2_pin[3:0]), .bus_drv(bus_drv),
    .nib_drv(nib_drv), .nib_en(nib_en));
  // Free-running core clock, 25 ns period
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Count falling edges of each strobe to see which one a cycle used
  always @(posedge clock) begin
    s_prev <= s_now;
    for (int j = 0; j < 4; j++) if (s_prev[j] && !s_now[j]) fall_cnt[j] <= fall_cnt[j] + 1;
  end
  task automatic give_verdict;
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge clock);
  endtask
  // One machine cycle requested by the core; strobe usage and length are checked
  task automatic cyc(input meb_kind_e k, input logic [11:0] ad, input logic [7:0] wd,
                     input logic l);
    int i, snap[4];
    logic [15:0] got, exp;
    snap = fall_cnt;
    cyc_req <= 1'b1;
    cyc_kind <= k;
    cyc_addr <= ad;
    cyc_wdata <= wd;
    cyc_last <= l;
    i = 0;
    do begin @(posedge clock); i++; end while (cyc_taken !== 1'b1 && i < 40);
    if (i >= 40) begin
      fails++;
      give_verdict();
    end
    cyc_req <= 1'b0;
    i = 0;
    do begin @(posedge clock); i++; end while (cyc_done !== 1'b1 && i < 40);
    if (i >= 40) begin
      fails++;
      give_verdict();
    end
    check("cycle length", 16'd15, 16'(i));
    for (int j = 0; j < 4; j++) got[j*4 +: 4] = 4'(fall_cnt[j] - snap[j]);
    exp = 16'h0000;
    if (k == MEB_K_FETCH) exp[12] = efs;
    if (k == MEB_K_DREAD) exp[8] = 1'b1;
    if (k == MEB_K_DWRITE) exp[4] = 1'b1;
    if (k == MEB_K_XREAD || k == MEB_K_XWRITE) exp[0] = 1'b1;
    check("strobe use", exp, got);
  endtask
  // Main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    srst = 1'b1;
    cyc_req = 1'b0;
    cyc_kind = MEB_K_IDLE;
    cyc_addr = 12'h000;
    cyc_wdata = 8'h00;
    cyc_last = 1'b0;
    coe = 1'b0;
    counter_run = 1'b0;
    irq_ack = 1'b0;
    p1_ext = 8'hff;
    p2_ext = 8'hff;
    t0_ext = 1'b1;
    t1_pin = 1'b1;
    irq_n = 1'b1;
    ss_n = 1'b1;
    efs = 1'b0;
    for (int i = 0; i < 256; i++) model[i] = 8'(i * 7 + 3);
    for (int i = 0; i < 4; i++) xm[i] = 4'h0;
    for (int i = 0; i < 4; i++) fall_cnt[i] = 0;
    n = $urandom(47);
    ticks(4);
    check("reset pins", 16'h003c, {9'h0, ale, code_n, rd_n, wr_n, xs_n, bus_oe, t0_oe});
    check("reset port", 16'h00ff, {p1_oe, p1_out});
    srst <= 1'b0;
    p1_ext <= 8'($urandom);
    p2_ext <= 8'($urandom);
    ticks(6);
    check("port1 input", {8'h0, p1_ext}, {8'h0, port1_level});
    check("port2 input", {8'h0, p2_ext}, {8'h0, port2_level});
    check("irq idle", 16'h0, {15'h0, irq_pending});
    n = 0;
    prev_ale = ale;
    repeat (150) begin
      @(posedge clock);
      if (ale && !prev_ale) n++;
      prev_ale = ale;
    end
    check("ale pulses", 16'd10, 16'(n));
    cyc(MEB_K_FETCH, 12'h123, 8'h00, 1'b0);
    efs <= 1'b1;
    ticks(5);
    for (int i = 0; i < 4; i++) begin
      a = 12'($urandom);
      cyc(MEB_K_FETCH, a, 8'h00, 1'b0);
      check("fetch byte", {8'h0, a[7:0] ^ {a[11:8], a[11:8]}}, {8'h0, cyc_rdata});
    end
    efs <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      a = 12'($urandom % 256);
      d = 8'($urandom);
      cyc(MEB_K_DREAD, a, 8'h00, 1'b0);
      check("data read", {8'h0, model[a[7:0]]}, {8'h0, cyc_rdata});
      cyc(MEB_K_DWRITE, a, d, 1'b0);
      model[a[7:0]] = d;
      cyc(MEB_K_DREAD, a, 8'h00, 1'b0);
      check("read back", {8'h0, model[a[7:0]]}, {8'h0, cyc_rdata});
    end
    for (int p = 0; p < 4; p++) begin
      d = 8'($urandom % 16);
      cyc(MEB_K_XWRITE, {8'h0, 2'b01, 2'(p)}, d, 1'b0);
      xm[p] = d[3:0];
    end
    for (int p = 0; p < 4; p++) begin
      cyc(MEB_K_XREAD, {8'h0, 2'b00, 2'(p)}, 8'h00, 1'b0);
      check("expander read", {12'h0, xm[p]}, {8'h0, cyc_rdata});
    end
    d = 8'($urandom);
    cyc(MEB_K_P1WR, 12'h000, d, 1'b0);
    cyc(MEB_K_P2WR, 12'h000, d, 1'b0);
    ticks(5);
    check("port1 out", {8'h0, d & p1_ext}, {8'h0, port1_level});
    check("port2 out", {8'h0, d & p2_ext}, {8'h0, port2_level});
    cyc(MEB_K_P1WR, 12'h000, 8'hff, 1'b0);
    p1_ext <= 8'($urandom);
    ticks(6);
    check("port1 reinput", {8'h0, p1_ext}, {8'h0, port1_level});
    for (int i = 0; i < 4; i++) begin
      {t0_ext, t1_pin, irq_n} <= 3'($urandom);
      ticks(6);
      check("pin levels", {13'h0, t0_ext, t1_pin, irq_n},
            {13'h0, test0_level, test1_level, irq_level_n});
    end
    irq_n <= 1'b0;
    ticks(6);
    check("irq set", 16'h1, {15'h0, irq_pending});
    irq_n <= 1'b1;
    ticks(6);
    check("irq sticky", 16'h1, {15'h0, irq_pending});
    irq_ack <= 1'b1;
    ticks(1);
    irq_ack <= 1'b0;
    ticks(3);
    check("irq clear", 16'h0, {15'h0, irq_pending});
    for (int r = 0; r < 2; r++) begin
      counter_run <= 1'(r);
      t1_pin <= 1'b1;
      ticks(6);
      t1_pin <= 1'b0;
      n = 0;
      repeat (10) begin
        @(posedge clock);
        if (t1_event === 1'b1) n++;
      end
      check("t1 events", 16'(r), 16'(n));
    end
    coe <= 1'b1;
    ticks(4);
    d[0] = t0_out;
    ticks(1);
    check("t0 clock out", {14'h0, 1'b1, ~d[0]}, {14'h0, t0_oe, t0_out});
    coe <= 1'b0;
    ticks(4);
    check("t0 released", 16'h0, {15'h0, t0_oe});
    ss_n <= 1'b0;
    cyc(MEB_K_DREAD, 12'h011, 8'h00, 1'b1);
    n = 0;
    while (step_halted !== 1'b1 && n < 30) begin @(posedge clock); n++; end
    if (n >= 30) begin
      fails++;
      give_verdict();
    end
    ticks(3);
    check("step halt", 16'h3, {14'h0, step_halted, ale});
    ss_n <= 1'b1;
    n = 0;
    while (step_halted !== 1'b0 && n < 30) begin @(posedge clock); n++; end
    if (n >= 30) begin
      fails++;
      give_verdict();
    end
    check("step resume", 16'h0, {15'h0, step_halted});
    cyc(MEB_K_DREAD, 12'h011, 8'h00, 1'b0);
    check("after step", {8'h0, model[8'h11]}, {8'h0, cyc_rdata});
    give_verdict();
  end
endmodule
`default_nettype wire
